// ### design/sxr_pkg.sv
// Constants, encodings and types for the diagnostic readout block.
// Assumes a single 25 MHz clock domain and one APB slave port.
package sxr_pkg;
   // Serial command opcodes
   localparam logic [7:0] SXR_OP_VERSION = 8'hB5; // Identification read
   localparam logic [6:0] SXR_OP_FAULT_HI = 7'h5C; // Fault read, bank select in bit 0
   localparam logic [7:0] SXR_OP_STATUS = 8'hC0; // Status pin select
   localparam logic [7:0] SXR_OP_CLEAR = 8'hFF; // Clear all fault flags
   localparam int SXR_CFG_ZERO_BIT = 7; // Must be zero in the config byte
   localparam int SXR_CFG_PIN_BIT = 6; // Pin select in the config byte
   localparam int SXR_CFG_SRC_LSB = 4; // Source field low bit
   // Flag positions, bank 0 in bits 7:0, bank 1 in bits 15:8
   localparam int SXR_FL_CMD = 0;
   localparam int SXR_FL_SPK = 1;
   localparam int SXR_FL_TEMP = 2;
   localparam int SXR_FL_SHORT = 3;
   localparam int SXR_FL_FLASH = 4;
   localparam int SXR_FL_WDT = 5;
   localparam int SXR_FL_RSTCNT = 6;
   localparam int SXR_FL_OSC = 7;
   localparam int SXR_FL_WAVE = 8;
   localparam int SXR_FL_BCLK = 12;
   localparam int SXR_FL_FCLK = 13;
   localparam int SXR_FL_AUDIO = 14;
   localparam int SXR_FL_MIX = 15;
   localparam logic [15:0] SXR_FLAG_MASK = 16'hF1FF; // Bank 1 bits 3..1 read zero
   // Status pin sources and reset selection
   localparam logic [1:0] SXR_SRC_BUSY = 2'h0;
   localparam logic [1:0] SXR_SRC_READY = 2'h1;
   localparam logic [1:0] SXR_PIN_A_SRC_RST = 2'h1;
   localparam logic [1:0] SXR_PIN_B_SRC_RST = 2'h0;
   localparam logic [3:0] SXR_MASK_RST = 4'h1;
   // APB map
   localparam logic [7:0] SXR_ADDR_CTRL = 8'h00; // W: bit0 clears all fault flags
   localparam logic [7:0] SXR_ADDR_FLAGS = 8'h04; // R: both flag banks
   localparam logic [7:0] SXR_ADDR_PINCFG = 8'h08; // RW: pin b [13:8], pin a [5:0]
   localparam logic [7:0] SXR_ADDR_INFO = 8'h0C; // R: link state and sound id
   localparam int SXR_PINB_LSB = 8;
   // Serial link state
   typedef enum logic [1:0] {SXR_OPCODE, SXR_REPLY, SXR_CONFIG, SXR_SKIP} sxr_state_e;
endpackage

// ### design/sxr_readout.sv
// Diagnostic readout: version read, fault read, status pin select, fault clear.
// Assumes serial pins synchronous to clock, host shifts MSB first and samples
// the reply on each rising serial clock edge; APB reaches the configuration.
// Detector inputs are level or pulse; each enabled high cycle sets its flag, but watchdog overflows after the first set the reset counter flag.
// Channel activity inputs come from the playback engines, one bit a channel.
// The clock enable freezes every register, serial and bus alike.
// One clock domain only, so there are no synchronisers inside.
// Serial link: chip select low frames a command, data MSB first.
// The reply shifter loads at opcode completion and shifts on each rise.
// APB: setup cycle loads read data, pready is always high.
// Unknown opcodes are ignored; a bad config byte flags a command error.
module sxr_readout (
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // Serial command link
   // Sampled by clock, taken as synchronous inputs
   input wire logic cmd_csn,
   input wire logic cmd_sck,
   input wire logic cmd_si,
   output logic cmd_so,
   // Sound data identification
   // Static byte stored with the sound data
   input wire logic [7:0] sound_id_byte,
   // Detection enables, bank 0 and bank 1 layout as the flags
   input wire logic [7:0] fault_enable_a,
   input wire logic [7:0] fault_enable_b,
   // Detector reports
   // Each is active high, level or pulse
   input wire logic bad_cmd_det,
   input wire logic speaker_open_det,
   input wire logic overtemp_det,
   input wire logic output_short_det,
   input wire logic flash_err_det,
   input wire logic watchdog_overflow,
   input wire logic reset_counter_overflow,
   input wire logic osc_stop_det,
   input wire logic wave_diff_det,
   input wire logic bit_clk_det,
   input wire logic frame_clk_det,
   input wire logic audio_in_det,
   input wire logic mix_count_det,
   // Channel activity
   // One bit per channel, level
   input wire logic [3:0] chan_processing,
   input wire logic [3:0] chan_standby,
   input wire logic [3:0] chan_playing,
   // Status outputs
   // All driven from the flops below
   output logic [3:0] cmd_ready_n,
   output logic [3:0] chan_busy_n,
   output logic status_pin_a,
   output logic status_pin_b,
   // APB slave
   // Byte addresses, word aligned, no byte enables
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import sxr_pkg::*;

   // Register naming: _reg holds state, _next is its next value
   // All registers share the asynchronous reset and the clock enable
   // Serial engine state
   sxr_state_e state_reg;
   sxr_state_e state_next;
   logic sck_prev_reg; // Last sampled serial clock
   logic [2:0] bit_cnt_reg; // Bits received in current byte
   logic [7:0] rx_reg; // Receive shifter
   logic [7:0] tx_reg; // Reply shifter
   logic [7:0] tx_next;
   // Fault state
   // Bank 0 in bits 7:0, bank 1 in bits 15:8
   logic [15:0] flags_reg;
   logic wdt_seen_reg; // One watchdog overflow already seen
   // Status pin configuration
   // Source and channel mask for each of the two pins
   logic [1:0] src_a_reg;
   logic [1:0] src_b_reg;
   logic [3:0] mask_a_reg;
   logic [3:0] mask_b_reg;

   // Decode of the serial stream
   // A byte completes on the eighth detected rise of the serial clock
   // Opcodes are only decoded in the opcode state, never mid-reply
   // The config byte is judged by its must-be-zero top bit
   wire sck_rise = cmd_sck && !sck_prev_reg;
   wire byte_done = sck_rise && !cmd_csn && (bit_cnt_reg == 3'h7);
   wire [7:0] rx_byte = {rx_reg[6:0], cmd_si};
   wire is_opcode = byte_done && (state_reg == SXR_OPCODE);
   wire op_version = is_opcode && (rx_byte == SXR_OP_VERSION);
   wire op_fault = is_opcode && (rx_byte[7:1] == SXR_OP_FAULT_HI);
   wire op_status = is_opcode && (rx_byte == SXR_OP_STATUS);
   wire op_clear = is_opcode && (rx_byte == SXR_OP_CLEAR);
   wire is_config = byte_done && (state_reg == SXR_CONFIG);
   wire cfg_bad = is_config && rx_byte[SXR_CFG_ZERO_BIT];
   wire cfg_ok = is_config && !rx_byte[SXR_CFG_ZERO_BIT];
   wire [1:0] cfg_src = rx_byte[SXR_CFG_SRC_LSB +: 2];
   wire [3:0] cfg_mask = rx_byte[3:0];

   // Decode of the APB access
   // Setup cycle loads read data; access cycle commits writes
   // Unmapped addresses are refused through pslverr
   // Only writes to the control and pin config words change state
   wire apb_setup = psel && !penable;
   wire apb_write = psel && penable && pwrite;
   wire hit_ctrl = (paddr == SXR_ADDR_CTRL);
   wire hit_flags = (paddr == SXR_ADDR_FLAGS);
   wire hit_pincfg = (paddr == SXR_ADDR_PINCFG);
   wire hit_info = (paddr == SXR_ADDR_INFO);
   wire addr_hit = hit_ctrl || hit_flags || hit_pincfg || hit_info;
   wire sw_clear = apb_write && hit_ctrl && pwdata[0];
   wire sw_cfg = apb_write && hit_pincfg;

   // Fault set terms, each gated by its enable
   // A disabled detector never sets its flag, whatever it reports
   // The second watchdog overflow only counts while the watchdog runs
   // Bank 1 bits 3 to 1 are masked off and always read zero
   wire [15:0] enables = {fault_enable_b, fault_enable_a} & SXR_FLAG_MASK;
   wire wdt_first = watchdog_overflow && !wdt_seen_reg;
   wire wdt_second = watchdog_overflow && wdt_seen_reg;
   logic [15:0] detect;
   always_comb begin
      detect = 16'h0000;
      // Unused bank 1 positions stay zero
      detect[SXR_FL_CMD] = bad_cmd_det || cfg_bad;
      detect[SXR_FL_SPK] = speaker_open_det;
      detect[SXR_FL_TEMP] = overtemp_det;
      detect[SXR_FL_SHORT] = output_short_det;
      detect[SXR_FL_FLASH] = flash_err_det;
      detect[SXR_FL_WDT] = wdt_first;
      detect[SXR_FL_RSTCNT] = reset_counter_overflow || (wdt_second && fault_enable_a[SXR_FL_WDT]);
      detect[SXR_FL_OSC] = osc_stop_det;
      detect[SXR_FL_WAVE] = wave_diff_det;
      detect[SXR_FL_BCLK] = bit_clk_det;
      detect[SXR_FL_FCLK] = frame_clk_det;
      detect[SXR_FL_AUDIO] = audio_in_det;
      detect[SXR_FL_MIX] = mix_count_det;
   end
   wire [15:0] flag_set = detect & enables;
   wire flag_clear = op_clear || sw_clear;
   // Set wins over clear, so a live fault stays flagged
   wire [15:0] flags_next = (flags_reg & ~{16{flag_clear}}) | flag_set;

   // Reply byte chosen when the opcode completes
   // The snapshot keeps the reply steady while flags move
   // Without a new opcode the shifter feeds zeros behind the reply
   wire [7:0] fault_reply = rx_byte[0] ? flags_reg[15:8] : flags_reg[7:0];
   always_comb begin
      // Default: shift the reply one place
      tx_next = {tx_reg[6:0], 1'b0};
      if (op_version) begin
         tx_next = sound_id_byte;
      end else if (op_fault) begin
         tx_next = fault_reply;
      end
   end

   // Next state of the serial engine
   // Opcode state waits for a command byte
   // Reply state lets the host clock out one byte
   // Config state takes the pin select byte
   // Unknown opcodes leave the engine in the opcode state
   always_comb begin
      state_next = state_reg;
      // Moves only at a byte boundary
      if (byte_done) begin
         case (state_reg)
            SXR_OPCODE: begin
               if (op_version || op_fault) begin
                  state_next = SXR_REPLY;
               end else if (op_status) begin
                  state_next = SXR_CONFIG;
               end
            end
            SXR_REPLY: state_next = SXR_OPCODE;
            SXR_CONFIG: state_next = SXR_OPCODE;
            default: state_next = SXR_OPCODE;
         endcase
      end
   end

   // Serial shifter and state, idled by chip select
   // Deselect resets the byte count, so a cut frame leaves no trace
   // The shifters move only on a detected serial clock rise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= SXR_OPCODE;
         sck_prev_reg <= 1'b0;
         bit_cnt_reg <= 3'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
      end else if (clk_en) begin
         // Edge detect sample, kept even while deselected
         sck_prev_reg <= cmd_sck;
         if (cmd_csn) begin
            // Deselect aborts any partial byte
            state_reg <= SXR_OPCODE;
            bit_cnt_reg <= 3'h0;
            tx_reg <= 8'h00;
         end else if (sck_rise) begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_reg <= rx_byte;
            tx_reg <= tx_next;
         end
      end
   end

   // Reply bit always shows the top of the shifter
   // Zero while idle, since deselect empties the shifter
   assign cmd_so = tx_reg[7];

   // Sticky fault flags and watchdog overflow memory
   // Flags only fall on a clear, and a live fault sets them again
   // The seen-overflow bit is forgotten on a clear as well
   // Set wins over clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags_reg <= 16'h0000;
         wdt_seen_reg <= 1'b0;
      end else if (clk_en) begin
         // Set terms and clear merged in flags_next
         flags_reg <= flags_next;
         if (watchdog_overflow && fault_enable_a[SXR_FL_WDT]) begin
            wdt_seen_reg <= 1'b1;
         end else if (flag_clear) begin
            wdt_seen_reg <= 1'b0;
         end
      end
   end

   // Status pin selection, serial command or APB write
   // Each pin keeps its own source and channel mask
   // A serial update of a pin wins over an APB write in the same cycle
   // An APB write updates both pins, except a pin that takes a serial update that cycle
   wire upd_a = (cfg_ok && !rx_byte[SXR_CFG_PIN_BIT]);
   wire upd_b = (cfg_ok && rx_byte[SXR_CFG_PIN_BIT]);
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         src_a_reg <= SXR_PIN_A_SRC_RST;
         src_b_reg <= SXR_PIN_B_SRC_RST;
         mask_a_reg <= SXR_MASK_RST;
         mask_b_reg <= SXR_MASK_RST;
      end else if (clk_en) begin
         // Pin a update
         if (upd_a) begin
            src_a_reg <= cfg_src;
            mask_a_reg <= cfg_mask;
         end else if (sw_cfg) begin
            src_a_reg <= pwdata[SXR_CFG_SRC_LSB +: 2];
            mask_a_reg <= pwdata[3:0];
         end
         // Pin b update, independent of pin a
         if (upd_b) begin
            src_b_reg <= cfg_src;
            mask_b_reg <= cfg_mask;
         end else if (sw_cfg) begin
            src_b_reg <= pwdata[SXR_PINB_LSB + SXR_CFG_SRC_LSB +: 2];
            mask_b_reg <= pwdata[SXR_PINB_LSB +: 4];
         end
      end
   end

   // Channel indications from channel activity
   // Both indications are active low, one bit per channel
   wire [3:0] ready_n_next = ~(chan_processing | chan_standby);
   wire [3:0] busy_n_next = ~(chan_processing | chan_playing);
   wire any_fault = |flags_reg;

   // Pin level for one source and channel mask
   // Source 00 busy, 01 ready, 10 or 11 fault
   // With busy or ready as source, an empty channel mask leaves the pin high
   function automatic logic pin_level(input logic [1:0] src, input logic [3:0] mask,
                                      input logic [3:0] busy_n, input logic [3:0] ready_n,
                                      input logic fault);
      logic lvl;
      lvl = fault;
      if (src == SXR_SRC_BUSY) begin
         lvl = &(busy_n | ~mask);
      end else if (src == SXR_SRC_READY) begin
         lvl = &(ready_n | ~mask);
      end
      return lvl;
   endfunction

   // Registered status outputs
   // Outputs lag the channel inputs by one clock
   // Reset shows no activity and no fault, so every output idles high
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_ready_n <= 4'hF;
         chan_busy_n <= 4'hF;
         status_pin_a <= 1'b1;
         status_pin_b <= 1'b1;
      end else if (clk_en) begin
         cmd_ready_n <= ready_n_next;
         chan_busy_n <= busy_n_next;
         status_pin_a <= pin_level(src_a_reg, mask_a_reg, busy_n_next, ready_n_next, any_fault);
         status_pin_b <= pin_level(src_b_reg, mask_b_reg, busy_n_next, ready_n_next, any_fault);
      end
   end

   // Read data mux for APB
   // Writable and read-only words share one mux
   // Unmapped addresses read as zero
   logic [31:0] rdata_next;
   always_comb begin
      rdata_next = 32'h0000_0000;
      // Flag word, pin config or info, else zero
      if (hit_flags) begin
         rdata_next[15:0] = flags_reg;
      end else if (hit_pincfg) begin
         rdata_next[SXR_CFG_SRC_LSB +: 2] = src_a_reg;
         rdata_next[3:0] = mask_a_reg;
         rdata_next[SXR_PINB_LSB + SXR_CFG_SRC_LSB +: 2] = src_b_reg;
         rdata_next[SXR_PINB_LSB +: 4] = mask_b_reg;
      end else if (hit_info) begin
         rdata_next[7:0] = sound_id_byte;
         rdata_next[SXR_PINB_LSB +: 2] = state_reg;
         rdata_next[SXR_PINB_LSB + 4 +: 3] = bit_cnt_reg;
      end
   end

   // Read data captured in the setup cycle
   // Read data then stands through the access cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && apb_setup) begin
         prdata <= rdata_next;
      end
   end

   // Slave always answers in the first access cycle
   // No wait states, so pready is constant
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
endmodule

// ### sim/sxr_readout_sva.sv
// Port-level checks for the diagnostic readout block.
// Assumes one clock domain; bound to the design by the statement at the foot.
module sxr_readout_sva
   import sxr_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic cmd_csn,
   input wire logic cmd_sck,
   input wire logic cmd_so,
   input wire logic [7:0] sound_id_byte,
   input wire logic [3:0] chan_processing,
   input wire logic [3:0] chan_standby,
   input wire logic [3:0] chan_playing,
   input wire logic [3:0] cmd_ready_n,
   input wire logic [3:0] chan_busy_n,
   input wire logic status_pin_a,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Address names one of the four registers
   wire logic hit = paddr inside {SXR_ADDR_CTRL, SXR_ADDR_FLAGS, SXR_ADDR_PINCFG, SXR_ADDR_INFO};
   chk_ready_track:
      assert property (!rst && clk_en |=> cmd_ready_n == ~($past(chan_processing) | $past(chan_standby))) else $error("ready off");
   chk_busy_track:
      assert property (!rst && clk_en |=> chan_busy_n == ~($past(chan_processing) | $past(chan_playing))) else $error("busy off");
   chk_reply_idle:
      assert property (cmd_csn [*2] |-> !cmd_so) else $error("reply line not idle");
   chk_reply_holds:
      assert property ((!cmd_csn && $stable(cmd_sck)) |=> $stable(cmd_so)) else $error("reply bit moved");
   chk_err_unmapped:
      assert property (psel && penable && !hit |-> pslverr && (pwrite || prdata == 32'h0)) else $error("not refused");
   chk_err_mapped:
      assert property (psel && penable && hit |-> pready && !pslverr) else $error("mapped refused");
   chk_id_read:
      assert property (psel && penable && !pwrite && paddr == SXR_ADDR_INFO |-> prdata[7:0] == $past(sound_id_byte))
         else $error("id read wrong");
   chk_pin_mask:
      assert property ((psel && penable && pwrite && paddr == SXR_ADDR_PINCFG && clk_en
         && pwdata[SXR_CFG_SRC_LSB +: 2] == SXR_SRC_BUSY && cmd_csn)
         ##1 (!penable && cmd_csn && clk_en) |=> status_pin_a == ~|(4'($past(pwdata, 2)) & ~chan_busy_n))
         else $error("pin a mask wrong");
endmodule
bind sxr_readout sxr_readout_sva i_sxr_readout_sva (.clock, .rst, .clk_en, .cmd_csn, .cmd_sck, .cmd_so, .sound_id_byte,
   .chan_processing, .chan_standby, .chan_playing, .cmd_ready_n, .chan_busy_n, .status_pin_a, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// ### sim/sxr_host.sv
// Host model of the serial command link: select, serial clock and data.
// Assumes the bench clock; every change follows a rising edge.
module sxr_host (
   input wire logic clock,
   output logic cmd_csn,
   output logic cmd_sck,
   output logic cmd_si,
   input wire logic cmd_so
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {cmd_csn, cmd_sck, cmd_si} = 3'b101;
   // One byte MSB first; each phase lasts three clocks so the sampler sees it
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         cmd_si <= tx[i];
         cmd_sck <= 1'b0;
         repeat (3) @(posedge clock);
         rx[i] = cmd_so; // Reply bit is settled before this rise
         cmd_sck <= 1'b1;
         repeat (3) @(posedge clock);
      end
   endtask
   // Whole frame: opcode, optional second byte, then release
   task automatic xfer(input logic [7:0] op, input logic [7:0] arg, input logic two, output logic [7:0] rx);
      logic [7:0] drop;
      cmd_csn <= 1'b0;
      @(posedge clock);
      shift(op, drop);
      if (two)
         shift(arg, rx);
      cmd_csn <= 1'b1;
      cmd_sck <= 1'b0; // Serial clock rests low between frames
      cmd_si <= ~cmd_si; // Released line shows the inverse of its last level
      @(posedge clock);
   endtask
endmodule

// ### sim/status_error_readout_test.sv
// Self-checking bench: serial host model, APB master, detector and channel stimulus.
// Assumes the design package and the bound checker are compiled first.
module status_error_readout_test
   import sxr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] ID = 8'hA6; // Sound id, arbitrary
   logic clock, rst, cmd_csn, cmd_sck, cmd_si, cmd_so, pin_a, pin_b, psel, penable, pwrite, pready, pslverr, err;
   logic [3:0] proc, stby, play, ready_n, busy_n;
   logic [7:0] en_a, en_b, paddr, rx;
   logic [15:0] det; // Detector reports in flag bit order
   logic [31:0] pwdata, prdata, rd;
   int n_errors, tests_run;
   logic run; // Clock enable of the design
   sxr_readout i_sxr_readout (.clock, .rst, .clk_en(run), .cmd_csn, .cmd_sck, .cmd_si, .cmd_so,
      .sound_id_byte(ID), .fault_enable_a(en_a), .fault_enable_b(en_b), .bad_cmd_det(det[0]),
      .speaker_open_det(det[1]), .overtemp_det(det[2]), .output_short_det(det[3]), .flash_err_det(det[4]),
      .watchdog_overflow(det[5]), .reset_counter_overflow(det[6]), .osc_stop_det(det[7]), .wave_diff_det(det[8]),
      .bit_clk_det(det[12]), .frame_clk_det(det[13]), .audio_in_det(det[14]), .mix_count_det(det[15]),
      .chan_processing(proc), .chan_standby(stby), .chan_playing(play), .cmd_ready_n(ready_n),
      .chan_busy_n(busy_n), .status_pin_a(pin_a), .status_pin_b(pin_b), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   sxr_host i_sxr_host (.clock, .cmd_csn, .cmd_sck, .cmd_si, .cmd_so);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer; read data and error land in rd and err
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clock);
   endtask
   task automatic pulse(input logic [15:0] v);
      det <= v;
      @(posedge clock);
      det <= '0;
      @(posedge clock);
   endtask
   // Fault read with the data line held low through the reply
   task automatic fault_is(input logic bank, input logic [7:0] exp);
      i_sxr_host.xfer({SXR_OP_FAULT_HI, bank}, 8'h00, 1'b1, rx);
      if (rx == 8'h00 && (pin_a || pin_b))
         i_sxr_host.xfer({SXR_OP_FAULT_HI, bank}, 8'h00, 1'b1, rx);
      check(32'(rx), 32'(exp));
   endtask
   task automatic pins_are(input logic [1:0] exp);
      repeat (3) @(posedge clock);
      check(32'({pin_a, pin_b}), 32'(exp));
   endtask
   initial begin
      {rst, psel, penable, pwrite, det, en_a, en_b, paddr, pwdata, proc, stby, play} = {4'h8, 84'h0};
      n_errors = 0;
      tests_run = 0;
      run = 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      stby <= 4'h1;
      proc <= 4'h2;
      pins_are(2'b01);
      check(32'({ready_n, busy_n}), 32'hCD);
      play <= 4'h1;
      pins_are(2'b00);
      $display("test reset_pins done");
      i_sxr_host.xfer(SXR_OP_VERSION, 8'h00, 1'b1, rx);
      check(32'(rx), 32'(ID));
      apb(1'b0, SXR_ADDR_INFO, 32'h0);
      check(32'(rd[7:0]), 32'(ID));
      pulse(16'hFFFF);
      fault_is(1'b0, 8'h00);
      fault_is(1'b1, 8'h00);
      {en_a, en_b} <= 16'hFFFF;
      pulse(16'hF1BF);
      fault_is(1'b0, 8'hBF);
      pulse(16'h0020);
      fault_is(1'b0, 8'hFF);
      fault_is(1'b1, 8'hF1);
      $display("test fault_flags done");
      i_sxr_host.xfer(SXR_OP_STATUS, 8'h60, 1'b1, rx);
      pins_are(2'b01);
      det <= 16'h0004;
      i_sxr_host.xfer(SXR_OP_CLEAR, 8'h00, 1'b0, rx);
      fault_is(1'b0, 8'h04);
      det <= '0;
      i_sxr_host.xfer(SXR_OP_CLEAR, 8'h00, 1'b0, rx);
      pins_are(2'b00);
      pulse(16'h0040);
      i_sxr_host.xfer(SXR_OP_STATUS, 8'h8F, 1'b1, rx);
      fault_is(1'b0, 8'h41);
      pins_are(2'b01);
      stby <= 4'h0;
      for (int s = 0; s < 4; s++) begin
         i_sxr_host.xfer(SXR_OP_STATUS, {2'b00, 2'(s), 4'h1}, 1'b1, rx);
         pins_are({s != 0, 1'b1});
      end
      i_sxr_host.xfer(SXR_OP_STATUS, 8'h0C, 1'b1, rx);
      pins_are(2'b11);
      play <= 4'h8;
      pins_are(2'b01);
      $display("test status_pins done");
      apb(1'b1, SXR_ADDR_PINCFG, 32'h0000_1403);
      apb(1'b0, SXR_ADDR_PINCFG, 32'h0);
      check(rd & 32'h3F3F, 32'h1403);
      pins_are(2'b01);
      apb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h1);
      apb(1'b0, SXR_ADDR_FLAGS, 32'h0);
      check(32'(rd[15:0]), 32'h0041);
      apb(1'b1, SXR_ADDR_CTRL, 32'h1);
      apb(1'b0, SXR_ADDR_FLAGS, 32'h0);
      check(32'(rd[15:0]), 32'h0);
      run <= 1'b0;
      pulse(16'h0004);
      run <= 1'b1;
      apb(1'b0, SXR_ADDR_FLAGS, 32'h0);
      check(32'(rd[15:0]), 32'h0);
      $display("test register_bus done");
      test_done();
   end
endmodule
